// file: sim/pin_ctl_model.sv
`default_nettype none
module pin_ctl_model (
    // Wanted pin states, high = asserted: halt, mask, line 1, line 0
    input wire logic       clock,
    input wire logic [3:0] cmd,
    // Package pins
    output logic           halt_request_n,
    output logic           addr_bit20_force_low_n,
    output logic           local_irq_line_1,
    output logic           local_irq_line_0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] pins_reg = 4'h0;
    // Pins move 1 ns after an edge, never on it, to avoid races
    always @(posedge clock) pins_reg <= #1 cmd;
    assign {halt_request_n, addr_bit20_force_low_n} = ~pins_reg[3:2];
    assign {local_irq_line_1, local_irq_line_0} = pins_reg[1:0];
endmodule
`default_nettype wire

// file: sim/pin_share_props.sv
`default_nettype none
module pin_share_props
    import pin_share_pkg::*;
#(parameter int N_THREADS = THREADS) (
    // Clock, reset and pins
    input wire logic                 clock,
    input wire logic                 resetn,
    input wire logic                 halt_request_n,
    input wire logic                 addr_bit20_force_low_n,
    input wire logic                 req_valid,
    input wire logic                 req_is_mem,
    input wire logic [ADDR_W-1:0]    req_addr,
    input wire logic                 snoop_valid,
    input wire logic [N_THREADS-1:0] thread_halted,
    // Outputs watched
    input wire logic                 stop_grant,
    input wire logic [N_THREADS-1:0] thread_run,
    input wire logic [N_THREADS-1:0] irq_accept_en,
    input wire logic [N_THREADS*LINT_COUNT-1:0] lint_pending,
    input wire logic                 bus_valid,
    input wire logic [ADDR_W-1:0]    bus_addr,
    input wire logic                 snoop_resp
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // Grant follows the pin within one edge, both ways
    a_halt_grant: assert property (!halt_request_n |=> stop_grant)
        else $error("no grant");
    a_halt_both: assert property (stop_grant |-> thread_run == '0)
        else $error("thread runs");
    a_grant_irq: assert property (stop_grant |-> irq_accept_en == '0)
        else $error("irq open");
    a_halt_release: assert property (
        halt_request_n && stop_grant |=> !stop_grant && &irq_accept_en)
        else $error("no resume");
    a_snoop_resp: assert property (snoop_valid |=> snoop_resp)
        else $error("no snoop answer");
    // Address path is one cycle late
    a_addr_mask: assert property (
        req_valid && req_is_mem && !addr_bit20_force_low_n
        |=> bus_valid && !bus_addr[A20_BIT]) else $error("bit 20 high");
    a_addr_pass: assert property (
        req_valid && addr_bit20_force_low_n
        |=> bus_addr == $past(req_addr)) else $error("addr changed");
    a_addr_low: assert property (req_valid |=>
        bus_addr[19:0] == $past(req_addr[19:0])) else $error("low bits");
    // Acks are ignored in grant, so no pending bit may drop
    a_pend_hold: assert property (stop_grant |=>
        (lint_pending & $past(lint_pending)) == $past(lint_pending))
        else $error("pending lost in grant");
    // Released pin: out of grant, threads follow their own halt state
    a_run_follow: assert property (halt_request_n |=>
        !stop_grant && thread_run == ~$past(thread_halted))
        else $error("threads not resumed");
endmodule
`default_nettype wire

// file: sim/tb.sv
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    fail_count++; $display("[ERR] %0t %0h %0h", $time, g, e); end end
module tb
    import pin_share_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clock = 1'b0, resetn = 1'b0, snoop_valid = 1'b0;
    logic              req_valid = 1'b0, req_is_mem = 1'b0;
    logic              halt_request_n, local_irq_line_0, local_irq_line_1;
    logic              addr_bit20_force_low_n, stop_grant;
    logic              bus_valid, snoop_resp;
    logic [3:0]        cmd = 4'h0, lint_mask = 4'h0, lint_pending;
    logic [1:0]        thread_halted = 2'h0, irq_ack = 2'h0;
    logic [1:0]        thread_run, irq_accept_en;
    logic [ADDR_W-1:0] req_addr = 32'h0, bus_addr;
    int                fail_count = 0, samples_checked = 0;
    shared_pin_thread_control dut (
        .clock                  (clock),
        .resetn                 (resetn),
        .halt_request_n         (halt_request_n),
        .local_irq_line_0       (local_irq_line_0),
        .local_irq_line_1       (local_irq_line_1),
        .addr_bit20_force_low_n (addr_bit20_force_low_n),
        .lint_mask              (lint_mask),
        .thread_halted          (thread_halted),
        .irq_ack                (irq_ack),
        .req_valid              (req_valid),
        .req_is_mem             (req_is_mem),
        .req_addr               (req_addr),
        .snoop_valid            (snoop_valid),
        .stop_grant             (stop_grant),
        .thread_run             (thread_run),
        .irq_accept_en          (irq_accept_en),
        .lint_pending           (lint_pending),
        .bus_valid              (bus_valid),
        .bus_addr               (bus_addr),
        .snoop_resp             (snoop_resp)
    );
    pin_ctl_model pm (
        .clock                  (clock),
        .cmd                    (cmd),
        .halt_request_n         (halt_request_n),
        .addr_bit20_force_low_n (addr_bit20_force_low_n),
        .local_irq_line_1       (local_irq_line_1),
        .local_irq_line_0       (local_irq_line_0)
    );
    // Clock, and a watchdog well past the expected run
    initial forever #5 clock = ~clock;
    initial begin
        #50us;
        fail_count++;
        close_out;
    end
    function automatic logic [31:0] masked(logic [31:0] a, logic c);
        a[A20_BIT] = a[A20_BIT] & !c;
        return a;
    endfunction
    task automatic step(int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task close_out;
        $display("checked %0d failed %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        void'($urandom(16923));
        step(5);
        resetn = 1'b1;
        // Reset leaves both threads running and open, nothing pending
        `CHK({stop_grant, thread_run, irq_accept_en, lint_pending}, 9'h0F0)
        // Random traffic under both mask pin levels
        for (int f = 0; f < 2; f++) begin
            cmd[2] = f[0];
            step(2);
            repeat (100) begin
                {req_valid, req_is_mem, snoop_valid} = 3'($urandom);
                req_addr = $urandom;
                step(1);
                `CHK(snoop_resp, snoop_valid)
                `CHK(bus_valid, req_valid)
                if (req_valid)
                    `CHK(bus_addr, masked(req_addr, req_is_mem & f[0]))
            end
        end
        {req_valid, snoop_valid} = 2'h0;
        // Every mask pattern, both lines rising together
        for (int m = 0; m < 16; m++) begin
            lint_mask = m[3:0];
            cmd[1:0] = 2'h3;
            step(2);
            `CHK(lint_pending, ~m[3:0])
            {cmd[1:0], irq_ack} = 4'h3;
            step(1);
            irq_ack = 2'h0;
            `CHK(lint_pending, 4'h0)
        end
        // Grant with one thread already halted; pending must hold
        {lint_mask, thread_halted, cmd} = 10'h011;
        step(2);
        cmd = 4'h8;
        step(2);
        `CHK({stop_grant, thread_run, irq_accept_en}, 5'h10)
        {irq_ack, snoop_valid} = 3'h7;
        step(1);
        {irq_ack, snoop_valid, cmd} = 7'h0;
        `CHK({snoop_resp, lint_pending}, 5'h15)
        step(2);
        `CHK({stop_grant, thread_run, irq_accept_en}, 5'h0B)
        irq_ack = 2'h3;
        step(1);
        irq_ack = 2'h0;
        `CHK(lint_pending, 4'h0)
        // Edge and ack in one cycle: the new edge must survive
        cmd = 4'h1;
        step(1);
        irq_ack = 2'h3;
        step(1);
        irq_ack = 2'h0;
        `CHK(lint_pending, 4'h5)
        close_out;
    end
endmodule
bind shared_pin_thread_control pin_share_props
    #(.N_THREADS(N_THREADS)) u_props (
    .clock                  (clock),
    .resetn                 (resetn),
    .halt_request_n         (halt_request_n),
    .addr_bit20_force_low_n (addr_bit20_force_low_n),
    .req_valid              (req_valid),
    .req_is_mem             (req_is_mem),
    .req_addr               (req_addr),
    .snoop_valid            (snoop_valid),
    .thread_halted          (thread_halted),
    .stop_grant             (stop_grant),
    .thread_run             (thread_run),
    .irq_accept_en          (irq_accept_en),
    .lint_pending           (lint_pending),
    .bus_valid              (bus_valid),
    .bus_addr               (bus_addr),
    .snoop_resp             (snoop_resp)
);
`default_nettype wire

// file: verilog/addr_mask_unit.sv
`default_nettype none
module addr_mask_unit
    import pin_share_pkg::*;
(
    // Request in
    input  wire bus_req_s in_req,
    // Mask control, active high here
    input  wire logic     force_low,
    // Request out
    output logic [ADDR_W-1:0] masked_addr
);
    wire logic clear_bit;

    // Only memory cycles lose bit 20; I/O keeps its address
    assign clear_bit = force_low & in_req.valid & in_req.is_mem;
    assign masked_addr = in_req.addr &
                         ~({{(ADDR_W-1){1'b0}}, clear_bit} << A20_BIT);
endmodule
`default_nettype wire

// file: verilog/pin_share_pkg.sv
`default_nettype none
package pin_share_pkg;
    localparam int THREADS      = 2;
    localparam int ADDR_W       = 32;
    localparam int A20_BIT      = 20;
    localparam int LINT_COUNT   = 2;
    localparam logic RUN_RESET  = 1'b1;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_GRANT
    } core_state_e;

    // One memory or I/O request toward the external bus
    typedef struct packed {
        logic              valid;
        logic              is_mem;
        logic [ADDR_W-1:0] addr;
    } bus_req_s;

    // Per-thread control view
    typedef struct packed {
        logic run_enable;
        logic irq_enable;
        logic [LINT_COUNT-1:0] lint_pending;
    } thread_ctl_s;
endpackage
`default_nettype wire

// file: verilog/shared_pin_thread_control.sv
`default_nettype none
module shared_pin_thread_control
    import pin_share_pkg::*;
#(
    parameter int N_THREADS = THREADS
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic resetn,
    // Shared package pins
    input  wire logic halt_request_n,
    input  wire logic local_irq_line_0,
    input  wire logic local_irq_line_1,
    input  wire logic addr_bit20_force_low_n,
    // Per-thread local vector masks, bit t*2+line
    input  wire logic [N_THREADS*LINT_COUNT-1:0] lint_mask,
    // Per-thread state and irq acknowledge from the cores
    input  wire logic [N_THREADS-1:0] thread_halted,
    input  wire logic [N_THREADS-1:0] irq_ack,
    // Memory or I/O request toward the external bus, from the active thread
    input  wire logic                 req_valid,
    input  wire logic                 req_is_mem,
    input  wire logic [ADDR_W-1:0]    req_addr,
    // Snoop in
    input  wire logic                 snoop_valid,
    // Outputs
    output logic                      stop_grant,
    output logic [N_THREADS-1:0]      thread_run,
    output logic [N_THREADS-1:0]      irq_accept_en,
    output logic [N_THREADS*LINT_COUNT-1:0] lint_pending,
    output logic                      bus_valid,
    output logic [ADDR_W-1:0]         bus_addr,
    output logic                      snoop_resp
);
    // Registered state; every output below comes from one of these
    core_state_e                     state_reg, state_next;
    logic                            grant_reg;
    logic [N_THREADS-1:0]            run_reg, run_next;
    logic [N_THREADS-1:0]            irqen_reg, irqen_next;
    logic [N_THREADS*LINT_COUNT-1:0] pend_reg, pend_next;
    logic                            bvalid_reg;
    logic [ADDR_W-1:0]               baddr_reg;
    logic                            snoop_reg;
    // Previous line levels, for edge detection
    logic [LINT_COUNT-1:0]           lint_prev_reg;

    // Decoded pins and next-state helpers
    wire logic                            halt_req;
    wire logic                            in_grant;
    wire logic                            grant_next;
    wire logic                            a20_force;
    wire logic [LINT_COUNT-1:0]           lint_now;
    wire logic [LINT_COUNT-1:0]           lint_rise;
    wire logic [N_THREADS-1:0]            ack_take;
    wire logic [N_THREADS*LINT_COUNT-1:0] lint_set;
    wire logic [N_THREADS*LINT_COUNT-1:0] lint_clr;
    wire logic [ADDR_W-1:0]               masked_addr;
    wire bus_req_s                        cur_req;

    // Per-thread enables: all clear while granted, else the given set
    function automatic logic [N_THREADS-1:0] gate_threads(
        input logic                 granted,
        input logic [N_THREADS-1:0] allowed
    );
        return granted ? '0 : allowed;
    endfunction

    // Copy the shared line vector into every thread's slice
    function automatic logic [N_THREADS*LINT_COUNT-1:0] fan_lines(
        input logic [LINT_COUNT-1:0] lines
    );
        logic [N_THREADS*LINT_COUNT-1:0] fanned;
        fanned = '0;
        for (int t = 0; t < N_THREADS; t++) begin
            fanned[t*LINT_COUNT +: LINT_COUNT] = lines;
        end
        return fanned;
    endfunction

    // Widen one flag per thread over all lines of that thread
    function automatic logic [N_THREADS*LINT_COUNT-1:0] fan_threads(
        input logic [N_THREADS-1:0] flags
    );
        logic [N_THREADS*LINT_COUNT-1:0] fanned;
        fanned = '0;
        for (int t = 0; t < N_THREADS; t++) begin
            fanned[t*LINT_COUNT +: LINT_COUNT] = {LINT_COUNT{flags[t]}};
        end
        return fanned;
    endfunction

    // Pin polarity decoding; the two control pins are active low
    assign halt_req  = ~halt_request_n;
    assign a20_force = ~addr_bit20_force_low_n;
    assign in_grant  = (state_reg == ST_GRANT);
    assign lint_now  = {local_irq_line_1, local_irq_line_0};

    // Edge detect; a line held high delivers only once
    // History resets to the idle low level, so no false edge after reset
    assign lint_rise = lint_now & ~lint_prev_reg;

    // State selection
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (halt_req) begin
                    state_next = ST_GRANT;
                end
            end
            ST_GRANT: begin
                if (!halt_req) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    // The request is honoured on the very edge that samples it
    assign grant_next = (state_next == ST_GRANT);

    // Thread enables follow the next state so they move with the grant
    // stop both threads
    assign run_next   = gate_threads(grant_next, ~thread_halted);
    assign irqen_next = gate_threads(grant_next, {N_THREADS{1'b1}});

    assign lint_set  = fan_lines(lint_rise) & ~lint_mask;
    // acks ignored while granted; grant also closes irqen
    assign ack_take  = irq_ack & irqen_reg & {N_THREADS{~in_grant}};
    assign lint_clr  = fan_threads(ack_take);
    // Set wins over clear, so an edge meeting an ack is not lost
    assign pend_next = (pend_reg & ~lint_clr) | lint_set;

    // Bus request as one packed word for the mask stage
    assign cur_req = '{valid: req_valid, is_mem: req_is_mem, addr: req_addr};

    addr_mask_unit u_mask (
        .in_req      (cur_req),
        .force_low   (a20_force),
        .masked_addr (masked_addr)
    );

    // Core state and the grant flag that drives the pin side
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_RUN;
            grant_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            grant_reg <= grant_next;
        end
    end

    // Thread execution and interrupt acceptance enables
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            run_reg   <= {N_THREADS{RUN_RESET}};
            irqen_reg <= {N_THREADS{RUN_RESET}};
        end else begin
            run_reg   <= run_next;
            irqen_reg <= irqen_next;
        end
    end

    // Pending interrupts; they stay latched through a grant
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pend_reg <= '0;
        end else begin
            pend_reg <= pend_next;
        end
    end

    // Line history for the edge detector
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lint_prev_reg <= '0;
        end else begin
            lint_prev_reg <= lint_now;
        end
    end

    // Outgoing bus request, one cycle behind the core side
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bvalid_reg <= 1'b0;
            baddr_reg  <= '0;
        end else begin
            bvalid_reg <= req_valid;
            baddr_reg  <= masked_addr;
        end
    end

    // snoops answered always
    // Not gated by the grant: caches must stay coherent while halted
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            snoop_reg <= 1'b0;
        end else begin
            snoop_reg <= snoop_valid;
        end
    end

    // Outputs straight from flops
    assign stop_grant    = grant_reg;
    assign thread_run    = run_reg;
    assign irq_accept_en = irqen_reg;
    assign lint_pending  = pend_reg;
    assign bus_valid     = bvalid_reg;
    assign bus_addr      = baddr_reg;
    assign snoop_resp    = snoop_reg;
endmodule
`default_nettype wire
